// ### rfif_bitstream.v
// Half-duplex radio bit-stream receiver and transmitter with an AXI4-Lite register slave.
// Assumes serial pins come from outside the clock domain; bus signals are on aclk.
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "rfif_map.vh"
module rfif_bitstream #(
  parameter FIFO_DEPTH_LOG2 = 2
) (
  input wire aclk,
  input wire aresetn,
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire serial_rx_data_in,
  input wire rx_bit_clock_in,
  input wire rx_match_in,
  output wire serial_tx_data_out,
  output reg tx_bit_clock_out,
  output wire pins_active,
  output wire irq_rx,
  output wire irq_tx
);
  reg [5:0] baud_reg;
  reg [7:0] coding_reg;
  reg [1:0] mode_reg;
  reg [7:0] pattern_reg;
  reg [3:0] irq_mask_reg;
  reg [3:0] irq_status_reg;
  reg tx_overrun_reg, rx_overrun_reg;
  reg aw_full_reg, w_full_reg, rd_pend_reg;
  reg [7:0] aw_addr_reg, ar_addr_reg, w_data_reg;
  reg w_lane_reg;
  reg rx_d_s1, rx_d_s2, clk_s1, clk_s2, clk_s3, match_s1, match_s2, match_s3;
  reg [2:0] filt_hist_reg;
  reg filt_reg;
  reg [15:0] rx_cnt_reg, tx_cnt_reg;
  reg prev_chip_reg, phase_reg, lock_phase_reg, started_reg;
  reg [7:0] win0_reg, win1_reg, rx_sh_reg, tx_sh_reg, tx_buf_reg;
  reg [3:0] rx_bits_reg, tx_bits_reg;
  reg tx_half_reg, tx_buf_valid_reg, tx_pend_reg;
  reg rx_full_d_reg, tx_empty_d_reg;
  reg [31:0] rdata_next;
  wire rx_active, tx_active, two_chip, ext_clk, tx_clk_en;
  wire [1:0] code;
  wire [1:0] start_mode;
  wire [15:0] chip_div;
  wire wr_fire, rd_fire, wr_hit, rd_stat, rd_rxdata;
  wire rx_edge, rx_chip_tick, rx_chip, dec_bit, bit_strobe, pattern_hit, ext_match;
  wire [7:0] win_new;
  wire rx_push, tx_push, tx_pop, tx_tick;
  wire rx_full, rx_empty, tx_full, tx_empty;
  wire [7:0] rx_pop_data, tx_pop_data;
  wire [3:0] irq_events;

  // The prescaler divides a chip from the bit period; two-chip codes run chips twice as fast.
  function [15:0] chip_cycles;
    input [5:0] sel;
    input two;
    reg [21:0] bit_cycles;
    begin
      bit_cycles = ({16'h0000, sel} + 22'h000001) * {6'h00, `RFIF_BAUD_UNIT_CYCLES};
      chip_cycles = two ? bit_cycles[16:1] : bit_cycles[15:0];
    end
  endfunction

  function is_two_chip;
    input [1:0] c;
    begin
      is_two_chip = (c == `RFIF_CODE_BIPHASE) || (c == `RFIF_CODE_MILLER);
    end
  endfunction

  // Receive wins when software enables both directions, so the line is never driven twice.
  assign rx_active = mode_reg[`RFIF_MODE_RX_EN_BIT];
  assign tx_active = mode_reg[`RFIF_MODE_TX_EN_BIT] & ~rx_active;
  assign pins_active = rx_active | tx_active;
  assign code = !coding_reg[`RFIF_CODING_ENABLE_BIT] ? `RFIF_CODE_NRZ :
    (coding_reg[2:0] == `RFIF_PCM_BIPHASE) ? `RFIF_CODE_BIPHASE :
    (coding_reg[2:0] == `RFIF_PCM_MILLER) ? `RFIF_CODE_MILLER : `RFIF_CODE_NRZ;
  assign two_chip = is_two_chip(code);
  assign chip_div = chip_cycles(baud_reg, two_chip);
  assign ext_clk = coding_reg[`RFIF_CODING_RX_EXT_CLK_BIT];
  assign tx_clk_en = coding_reg[`RFIF_CODING_TX_CLK_OUT_BIT];
  assign start_mode = coding_reg[`RFIF_CODING_START_HI:`RFIF_CODING_START_LO];

  // Register bus: address and data are taken in either order, answered once both are held.
  assign s_axi_awready = ~aw_full_reg & ~s_axi_bvalid;
  assign s_axi_wready = ~w_full_reg & ~s_axi_bvalid;
  assign s_axi_arready = ~rd_pend_reg & ~s_axi_rvalid;
  assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign wr_hit = (aw_addr_reg <= `RFIF_ADDR_IRQ_MASK) && (aw_addr_reg[1:0] == 2'h0) &&
    (aw_addr_reg != `RFIF_ADDR_RX_DATA);
  assign rd_fire = rd_pend_reg;
  assign rd_stat = rd_fire && (ar_addr_reg == `RFIF_ADDR_IRQ_STATUS);
  assign rd_rxdata = s_axi_arvalid & s_axi_arready & (s_axi_araddr == `RFIF_ADDR_RX_DATA);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      w_full_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      ar_addr_reg <= 8'h00;
      w_data_reg <= 8'h00;
      w_lane_reg <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RFIF_RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= `RFIF_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata[7:0];
        w_lane_reg <= s_axi_wstrb[0];
      end
      if (wr_fire) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? `RFIF_RESP_OKAY : `RFIF_RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
        rd_pend_reg <= 1'b1;
        ar_addr_reg <= s_axi_araddr;
      end
      // The extra cycle lets a popped receive byte settle in the buffer's output register.
      if (rd_fire) begin
        rd_pend_reg <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rdata_next;
        s_axi_rresp <= ((ar_addr_reg <= `RFIF_ADDR_IRQ_MASK) && (ar_addr_reg[1:0] == 2'h0) &&
          (ar_addr_reg != `RFIF_ADDR_TX_DATA)) ? `RFIF_RESP_OKAY : `RFIF_RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  always @* begin
    rdata_next = 32'h00000000;
    case (ar_addr_reg)
      `RFIF_ADDR_BAUD: rdata_next[5:0] = baud_reg;
      `RFIF_ADDR_CODING: rdata_next[7:0] = coding_reg;
      `RFIF_ADDR_MODE: rdata_next[1:0] = mode_reg;
      `RFIF_ADDR_TX_STATUS: rdata_next[3:0] = {tx_overrun_reg, tx_full, tx_empty,
        tx_empty & ~tx_pend_reg & ~tx_buf_valid_reg & (tx_bits_reg == 4'h0)};
      `RFIF_ADDR_RX_DATA: rdata_next[7:0] = rx_pop_data;
      `RFIF_ADDR_RX_STATUS: rdata_next[4:0] = {rx_overrun_reg, rx_full,
        irq_status_reg[`RFIF_IRQ_START_DET], started_reg & rx_active, ~rx_empty};
      `RFIF_ADDR_START_PATTERN: rdata_next[7:0] = pattern_reg;
      `RFIF_ADDR_IRQ_STATUS: rdata_next[3:0] = irq_status_reg;
      `RFIF_ADDR_IRQ_MASK: rdata_next[3:0] = irq_mask_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      baud_reg <= `RFIF_BAUD_RESET;
      coding_reg <= `RFIF_CODING_RESET;
      mode_reg <= `RFIF_MODE_RESET;
      pattern_reg <= `RFIF_PATTERN_RESET;
      irq_mask_reg <= `RFIF_MASK_RESET;
    end else if (wr_fire && w_lane_reg) begin
      case (aw_addr_reg)
        `RFIF_ADDR_BAUD: baud_reg <= w_data_reg[5:0];
        `RFIF_ADDR_CODING: coding_reg <= w_data_reg;
        `RFIF_ADDR_MODE: mode_reg <= w_data_reg[1:0];
        `RFIF_ADDR_START_PATTERN: pattern_reg <= w_data_reg;
        `RFIF_ADDR_IRQ_MASK: irq_mask_reg <= w_data_reg[3:0];
        default: mode_reg <= mode_reg;
      endcase
    end
  end

  // Pins cross into aclk through two flip-flops before anything looks at them.
  always @(posedge aclk) begin
    if (!aresetn) begin
      {rx_d_s1, rx_d_s2, clk_s1, clk_s2, clk_s3} <= 5'h00;
      {match_s1, match_s2, match_s3} <= 3'h0;
      filt_hist_reg <= 3'h0;
      filt_reg <= 1'b0;
    end else begin
      rx_d_s1 <= serial_rx_data_in;
      rx_d_s2 <= rx_d_s1;
      clk_s1 <= rx_bit_clock_in;
      clk_s2 <= clk_s1;
      clk_s3 <= clk_s2;
      match_s1 <= rx_match_in;
      match_s2 <= match_s1;
      match_s3 <= match_s2;
      filt_hist_reg <= {filt_hist_reg[1:0], rx_d_s2};
      // Majority of three rejects single-sample glitches at the cost of three cycles of lag.
      filt_reg <= (filt_hist_reg[0] & filt_hist_reg[1]) | (filt_hist_reg[1] & filt_hist_reg[2]) |
        (filt_hist_reg[0] & filt_hist_reg[2]);
    end
  end

  // Recovered clock re-centres when filt_reg and filt_hist_reg[2] differ, which a clean filtered edge never causes; the external clock replaces it whole.
  assign rx_edge = filt_reg ^ filt_hist_reg[2];
  assign rx_chip_tick = ext_clk ? (clk_s2 & ~clk_s3) : (rx_cnt_reg == 16'h0000);
  assign rx_chip = ext_clk ? rx_d_s2 : filt_reg;
  assign bit_strobe = rx_chip_tick & (~two_chip | (phase_reg == lock_phase_reg));
  assign win_new = {(phase_reg ? win1_reg[6:0] : win0_reg[6:0]), dec_bit};
  assign pattern_hit = (start_mode == `RFIF_START_PATTERN) && rx_chip_tick &&
    (two_chip || !phase_reg) && (win_new == pattern_reg);
  assign ext_match = (start_mode == `RFIF_START_EXTERNAL) && match_s2 && !match_s3;
  assign rx_push = rx_active & started_reg & bit_strobe & (rx_bits_reg == 4'h7);

  always @(posedge aclk) begin
    if (!aresetn || !rx_active) begin
      rx_cnt_reg <= 16'h0000;
      prev_chip_reg <= 1'b0;
      phase_reg <= 1'b0;
      lock_phase_reg <= 1'b1;
      started_reg <= 1'b0;
      win0_reg <= 8'h00;
      win1_reg <= 8'h00;
      rx_sh_reg <= 8'h00;
      rx_bits_reg <= 4'h0;
    end else begin
      if (rx_edge) begin
        rx_cnt_reg <= {1'b0, chip_div[15:1]};
      end else if (rx_cnt_reg == 16'h0000) begin
        rx_cnt_reg <= chip_div - 16'h0001;
      end else begin
        rx_cnt_reg <= rx_cnt_reg - 16'h0001;
      end
      if (rx_chip_tick) begin
        prev_chip_reg <= rx_chip;
        phase_reg <= two_chip & ~phase_reg;
        if (phase_reg) begin
          win1_reg <= win_new;
        end else begin
          win0_reg <= win_new;
        end
      end
      if (!started_reg) begin
        if (start_mode == `RFIF_START_BYPASS || start_mode == 2'h3) begin
          started_reg <= 1'b1;
        end else if (pattern_hit) begin
          started_reg <= 1'b1;
          lock_phase_reg <= phase_reg;
        end else if (ext_match) begin
          started_reg <= 1'b1;
          lock_phase_reg <= 1'b0;
          phase_reg <= 1'b0;
        end
      end else if (bit_strobe) begin
        rx_sh_reg <= {rx_sh_reg[6:0], dec_bit};
        rx_bits_reg <= (rx_bits_reg == 4'h7) ? 4'h0 : rx_bits_reg + 4'h1;
      end
    end
  end

  rfif_fifo #(.WIDTH(8), .DEPTH_LOG2(FIFO_DEPTH_LOG2)) rx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(wr_fire && w_lane_reg && aw_addr_reg == `RFIF_ADDR_RX_STATUS),
    .push(rx_push),
    .push_data({rx_sh_reg[6:0], dec_bit}),
    .pop(rd_rxdata),
    .pop_data_reg(rx_pop_data),
    .full(rx_full),
    .empty(rx_empty)
  );

  // Transmit: one byte waits in a holding register so the shifter reloads with no gap.
  assign tx_push = wr_fire & w_lane_reg & (aw_addr_reg == `RFIF_ADDR_TX_DATA);
  assign tx_pop = tx_active & ~tx_empty & ~tx_pend_reg & ~tx_buf_valid_reg;
  assign tx_tick = tx_active & (tx_cnt_reg == 16'h0000) & (tx_bits_reg != 4'h0);

  always @(posedge aclk) begin
    if (!aresetn || !tx_active) begin
      tx_cnt_reg <= 16'h0000;
      tx_sh_reg <= 8'h00;
      tx_buf_reg <= 8'h00;
      tx_bits_reg <= 4'h0;
      tx_half_reg <= 1'b0;
      tx_buf_valid_reg <= 1'b0;
      tx_pend_reg <= 1'b0;
      tx_bit_clock_out <= 1'b0;
    end else begin
      tx_pend_reg <= tx_pop;
      if (tx_pend_reg) begin
        tx_buf_reg <= tx_pop_data;
        tx_buf_valid_reg <= 1'b1;
      end
      if (tx_bits_reg == 4'h0 && tx_buf_valid_reg) begin
        tx_sh_reg <= tx_buf_reg;
        tx_bits_reg <= 4'h8;
        tx_half_reg <= 1'b0;
        tx_buf_valid_reg <= 1'b0;
        tx_cnt_reg <= 16'h0000;
      end else if (tx_tick) begin
        tx_cnt_reg <= chip_div - 16'h0001;
        tx_bit_clock_out <= tx_clk_en;
        if (two_chip && !tx_half_reg) begin
          tx_half_reg <= 1'b1;
        end else begin
          tx_half_reg <= 1'b0;
          tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
          tx_bits_reg <= tx_bits_reg - 4'h1;
        end
      end else if (tx_cnt_reg != 16'h0000) begin
        tx_cnt_reg <= tx_cnt_reg - 16'h0001;
        if (tx_cnt_reg == {1'b0, chip_div[15:1]}) begin
          tx_bit_clock_out <= 1'b0;
        end
      end
    end
  end

  rfif_fifo #(.WIDTH(8), .DEPTH_LOG2(FIFO_DEPTH_LOG2)) tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(wr_fire && w_lane_reg && aw_addr_reg == `RFIF_ADDR_TX_STATUS),
    .push(tx_push),
    .push_data(w_data_reg),
    .pop(tx_pop),
    .pop_data_reg(tx_pop_data),
    .full(tx_full),
    .empty(tx_empty)
  );

  rfif_pcm_codec codec (
    .aclk(aclk),
    .aresetn(aresetn),
    .code(code),
    .dec_first(prev_chip_reg),
    .dec_second(rx_chip),
    .dec_bit(dec_bit),
    .enc_clear(~tx_active),
    .enc_step(tx_tick),
    .enc_bit(tx_sh_reg[7]),
    .enc_half(tx_half_reg),
    .enc_chip_reg(serial_tx_data_out)
  );

  assign irq_events = {tx_empty & ~tx_empty_d_reg & tx_active, rx_push,
    rx_full & ~rx_full_d_reg, (pattern_hit | ext_match) & ~started_reg};

  // Overrun and interrupt flags: a new event in the clearing cycle keeps its flag set.
  always @(posedge aclk) begin
    if (!aresetn) begin
      irq_status_reg <= 4'h0;
      tx_overrun_reg <= 1'b0;
      rx_overrun_reg <= 1'b0;
      rx_full_d_reg <= 1'b0;
      tx_empty_d_reg <= 1'b1;
    end else begin
      rx_full_d_reg <= rx_full;
      tx_empty_d_reg <= tx_empty;
      irq_status_reg <= (rd_stat ? 4'h0 : irq_status_reg) | irq_events;
      tx_overrun_reg <= (tx_push & tx_full) |
        (tx_overrun_reg & ~(wr_fire & w_lane_reg & aw_addr_reg == `RFIF_ADDR_TX_STATUS));
      rx_overrun_reg <= (rx_push & rx_full) |
        (rx_overrun_reg & ~(wr_fire & w_lane_reg & aw_addr_reg == `RFIF_ADDR_RX_STATUS));
    end
  end

  assign irq_rx = |(irq_status_reg[2:0] & irq_mask_reg[2:0]);
  assign irq_tx = irq_status_reg[`RFIF_IRQ_TX_EMPTY] & irq_mask_reg[`RFIF_IRQ_TX_EMPTY];
endmodule // rfif_bitstream

// ### rfif_map.vh
// Register offsets, field positions, reset values and timing for the radio bit-stream interface.
// Assumes a 32-bit AXI4-Lite register bus; every register sits in the low byte of one word.
`ifndef RFIF_MAP_VH
`define RFIF_MAP_VH

`define RFIF_ADDR_BAUD 8'h00
`define RFIF_ADDR_CODING 8'h04
`define RFIF_ADDR_MODE 8'h08
`define RFIF_ADDR_TX_DATA 8'h0c
`define RFIF_ADDR_TX_STATUS 8'h10
`define RFIF_ADDR_RX_DATA 8'h14
`define RFIF_ADDR_RX_STATUS 8'h18
`define RFIF_ADDR_START_PATTERN 8'h1c
`define RFIF_ADDR_IRQ_STATUS 8'h20
`define RFIF_ADDR_IRQ_MASK 8'h24

`define RFIF_CODING_START_HI 7
`define RFIF_CODING_START_LO 6
`define RFIF_CODING_ENABLE_BIT 5
`define RFIF_CODING_RX_EXT_CLK_BIT 4
`define RFIF_CODING_TX_CLK_OUT_BIT 3
`define RFIF_CODING_PCM_HI 2
`define RFIF_CODING_PCM_LO 0
`define RFIF_MODE_RX_EN_BIT 1
`define RFIF_MODE_TX_EN_BIT 0

`define RFIF_BAUD_RESET 6'h00
`define RFIF_CODING_RESET 8'h00
`define RFIF_MODE_RESET 2'h0
`define RFIF_PATTERN_RESET 8'h00
`define RFIF_MASK_RESET 4'h0

`define RFIF_PCM_NRZ 3'h0
`define RFIF_PCM_BIPHASE 3'h1
`define RFIF_PCM_MILLER 3'h2
`define RFIF_CODE_NRZ 2'h0
`define RFIF_CODE_BIPHASE 2'h1
`define RFIF_CODE_MILLER 2'h2

`define RFIF_START_BYPASS 2'h0
`define RFIF_START_PATTERN 2'h1
`define RFIF_START_EXTERNAL 2'h2

`define RFIF_IRQ_START_DET 0
`define RFIF_IRQ_RX_FULL 1
`define RFIF_IRQ_RX_BYTE 2
`define RFIF_IRQ_TX_EMPTY 3

`define RFIF_BAUD_UNIT_CYCLES 16'd16
`define RFIF_RESP_OKAY 2'h0
`define RFIF_RESP_SLVERR 2'h2

`endif

// ### rfif_fifo.v
// Small synchronous FIFO with registered read data for the byte buffers.
// Assumes one clock; pop and clear are single-cycle strobes from the same domain.
`timescale 1ns/1ps
module rfif_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH_LOG2 = 2
) (
  input wire aclk,
  input wire aresetn,
  input wire clear,
  input wire push,
  input wire [WIDTH-1:0] push_data,
  input wire pop,
  output reg [WIDTH-1:0] pop_data_reg,
  output wire full,
  output wire empty
);
  localparam DEPTH = 1 << DEPTH_LOG2;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [DEPTH_LOG2:0] wptr_reg;
  reg [DEPTH_LOG2:0] rptr_reg;
  wire do_push;
  wire do_pop;

  assign full = (wptr_reg[DEPTH_LOG2] != rptr_reg[DEPTH_LOG2]) &&
    (wptr_reg[DEPTH_LOG2-1:0] == rptr_reg[DEPTH_LOG2-1:0]);
  assign empty = (wptr_reg == rptr_reg);
  // A push into a full buffer or a pop from an empty one is dropped here.
  assign do_push = push & ~full;
  assign do_pop = pop & ~empty;

  always @(posedge aclk) begin
    if (do_push) begin
      mem[wptr_reg[DEPTH_LOG2-1:0]] <= push_data;
    end
  end

  always @(posedge aclk) begin
    if (!aresetn || clear) begin
      wptr_reg <= {(DEPTH_LOG2+1){1'b0}};
      rptr_reg <= {(DEPTH_LOG2+1){1'b0}};
      pop_data_reg <= {WIDTH{1'b0}};
    end else begin
      if (do_push) begin
        wptr_reg <= wptr_reg + 1'b1;
      end
      if (do_pop) begin
        pop_data_reg <= mem[rptr_reg[DEPTH_LOG2-1:0]];
        rptr_reg <= rptr_reg + 1'b1;
      end
    end
  end
endmodule // rfif_fifo

// ### rfif_pcm_codec.v
// PCM chip coder: combinational decoder of one bit from its chips, registered encoder.
// Assumes the caller steps the encoder once per chip and gives the chip index within the bit.
`timescale 1ns/1ps
`include "rfif_map.vh"
module rfif_pcm_codec (
  input wire aclk,
  input wire aresetn,
  input wire [1:0] code,
  input wire dec_first,
  input wire dec_second,
  output reg dec_bit,
  input wire enc_clear,
  input wire enc_step,
  input wire enc_bit,
  input wire enc_half,
  output reg enc_chip_reg
);
  reg last_bit_reg;
  reg enc_chip_next;

  always @* begin
    case (code)
      `RFIF_CODE_BIPHASE: dec_bit = dec_first;
      `RFIF_CODE_MILLER: dec_bit = dec_first ^ dec_second;
      default: dec_bit = dec_second;
    endcase
  end

  // Miller keeps the line level and toggles it mid-bit for a one, and at a bit edge
  // only between two zeros, so the chip register itself is the code state.
  always @* begin
    case (code)
      `RFIF_CODE_BIPHASE: enc_chip_next = enc_half ? ~enc_bit : enc_bit;
      `RFIF_CODE_MILLER: begin
        if (enc_half) begin
          enc_chip_next = enc_bit ? ~enc_chip_reg : enc_chip_reg;
        end else begin
          enc_chip_next = (!enc_bit && !last_bit_reg) ? ~enc_chip_reg : enc_chip_reg;
        end
      end
      default: enc_chip_next = enc_bit;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn || enc_clear) begin
      enc_chip_reg <= 1'b0;
      last_bit_reg <= 1'b1;
    end else if (enc_step) begin
      enc_chip_reg <= enc_chip_next;
      if (enc_half || code != `RFIF_CODE_MILLER) begin
        last_bit_reg <= enc_bit;
      end
    end
  end
endmodule // rfif_pcm_codec

// ### rfif_bitstream_properties.sv
// Port-level assertions for the radio bit-stream interface.
// Bound to the top module; one clock, synchronous active-low reset.
`timescale 1ns/1ps
module rfif_bitstream_properties #(
  parameter FIFO_DEPTH_LOG2 = 2
) (
  input aclk,
  input aresetn,
  input s_axi_awvalid,
  input s_axi_awready,
  input s_axi_wvalid,
  input s_axi_wready,
  input [1:0] s_axi_bresp,
  input s_axi_bvalid,
  input s_axi_bready,
  input s_axi_arvalid,
  input s_axi_arready,
  input [31:0] s_axi_rdata,
  input s_axi_rvalid,
  input s_axi_rready,
  input serial_tx_data_out,
  input tx_bit_clock_out,
  input pins_active,
  input irq_rx,
  input irq_tx
);
  default clocking @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  write_answer_due_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |-> ##[1:3] s_axi_bvalid) else $error("write answer late");
  read_answer_due_a: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:3] s_axi_rvalid)
    else $error("read answer late");
  write_answer_holds_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write answer dropped");
  read_answer_holds_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read answer dropped");
  write_refused_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  read_refused_a: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  tx_idle_low_a: assert property (
    !pins_active [*2] |-> !serial_tx_data_out && !tx_bit_clock_out) else $error("tx pins busy");
  reset_irq_quiet_a: assert property (
    $rose(aresetn) |-> !irq_rx && !irq_tx) else $error("interrupt out of reset");
  // The shortest chip lasts eight cycles, except a byte's last chip, which a shifter reload can cut to two.
  chip_length_a: assert property (
    pins_active && $changed(serial_tx_data_out) |=>
    ($stable(serial_tx_data_out) || !pins_active) [*6]) else $error("tx chip too short");
  cover property (s_axi_rvalid && s_axi_rready);
  cover property ($rose(irq_rx));
  cover property ($rose(irq_tx));
endmodule // rfif_bitstream_properties

bind rfif_bitstream rfif_bitstream_properties #(.FIFO_DEPTH_LOG2(FIFO_DEPTH_LOG2)) props_i (.*);

// ### rfif_radio_model.sv
// Radio stand-in driving receive chips, bit clock and match pulse.
// Assumes baud setting 0: one bit lasts 16 cycles.
`timescale 1ns/1ps
module rfif_radio_model (
  input wire aclk,
  output reg serial_rx_data_in,
  output reg rx_bit_clock_in,
  output reg rx_match_in
);
  reg last_bit = 1'b1;
  initial begin
    serial_rx_data_in = 1'b1;
    rx_bit_clock_in = 1'b0;
    rx_match_in = 1'b0;
  end
  task chip(input v, input integer n);
    begin
      @(posedge aclk);
      serial_rx_data_in <= v;
      rx_bit_clock_in <= 1'b0;
      repeat (n / 2) @(posedge aclk);
      rx_bit_clock_in <= 1'b1;
      repeat (n / 2 - 1) @(posedge aclk);
    end
  endtask
  // Code 0 NRZ, 1 bi-phase, 2 Miller; ends on the inverted level.
  task send(input [23:0] w, input [1:0] code);
    integer i;
    reg c;
    begin
      for (i = 23; i >= 0; i = i - 1) begin
        c = (code == 2'h2) ? serial_rx_data_in ^ (!w[i] && !last_bit) : w[i];
        last_bit = w[i];
        chip(c, code == 2'h0 ? 16 : 8);
        if (code != 2'h0) chip(c ^ (code == 2'h2 ? w[i] : 1'b1), 8);
      end
      @(posedge aclk);
      serial_rx_data_in <= !serial_rx_data_in;
      rx_bit_clock_in <= 1'b0;
    end
  endtask
  task match_pulse;
    begin
      @(posedge aclk);
      rx_match_in <= 1'b1;
      repeat (4) @(posedge aclk);
      rx_match_in <= 1'b0;
    end
  endtask
endmodule // rfif_radio_model

// ### rf_pcm_bitstream_interface_tb.sv
// Self-checking bench for the radio bit-stream interface.
// Assumes the map header and the radio model.
`timescale 1ns/1ps
`include "rfif_map.vh"
`define CHK(nm, e, g) begin total_checks = total_checks + 1; if ((g) !== (e)) begin \
  num_errors = num_errors + 1; $display("mismatch %s expected %h seen %h", nm, e, g); end end
module rf_pcm_bitstream_interface_tb;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire serial_rx_data_in, rx_bit_clock_in, rx_match_in;
  wire serial_tx_data_out, tx_bit_clock_out, pins_active, irq_rx, irq_tx;
  integer num_errors = 0, total_checks = 0;
  rfif_bitstream #(.FIFO_DEPTH_LOG2(2)) rfif_bitstream_i (.*);
  rfif_radio_model rfif_radio_model_i (.*);
  always #20 aclk = ~aclk;
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task hang;
    begin
      $display("mismatch wait expected done seen timeout");
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d, input [1:0] er = 2'h0);
    integer n;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (n = 0; n < 50 && !(s_axi_bvalid && s_axi_bready); n = n + 1) begin
        @(posedge aclk);
        if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      if (n == 50) hang;
      s_axi_bready <= 1'b0;
      `CHK("bresp", er, s_axi_bresp)
    end
  endtask
  task rd(input [7:0] a, input [7:0] m, input [7:0] e, input [1:0] er = 2'h0);
    integer n;
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (n = 0; n < 50 && !(s_axi_rvalid && s_axi_rready); n = n + 1) begin
        @(posedge aclk);
        if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      if (n == 50) hang;
      s_axi_rready <= 1'b0;
      `CHK("rdata", {24'h0, e}, s_axi_rdata & {24'h0, m})
      `CHK("rresp", er, s_axi_rresp)
    end
  endtask
  task test_regs;
    begin
      rd(`RFIF_ADDR_BAUD, 8'hff, 8'h00);
      rd(`RFIF_ADDR_CODING, 8'hff, 8'h00);
      rd(`RFIF_ADDR_MODE, 8'hff, 8'h00);
      rd(`RFIF_ADDR_START_PATTERN, 8'hff, 8'h00);
      rd(`RFIF_ADDR_IRQ_MASK, 8'hff, 8'h00);
      rd(`RFIF_ADDR_TX_STATUS, 8'h0e, 8'h02);
      rd(`RFIF_ADDR_RX_STATUS, 8'h1f, 8'h00);
      rd(`RFIF_ADDR_TX_DATA, 8'h00, 8'h00, `RFIF_RESP_SLVERR);
      rd(8'h30, 8'h00, 8'h00, `RFIF_RESP_SLVERR);
      wr(`RFIF_ADDR_RX_DATA, 8'h00, `RFIF_RESP_SLVERR);
      wr(8'h30, 8'h00, `RFIF_RESP_SLVERR);
      wr(`RFIF_ADDR_CODING, 8'hb2);
      rd(`RFIF_ADDR_CODING, 8'hff, 8'hb2);
      $display("register test done");
    end
  endtask
  // Receive wins over transmit, so the queued byte must never leave.
  task test_duplex;
    integer k;
    reg seen;
    begin
      seen = 1'b0;
      wr(`RFIF_ADDR_TX_STATUS, 8'h00);
      wr(`RFIF_ADDR_CODING, 8'h00);
      wr(`RFIF_ADDR_TX_DATA, 8'hff);
      wr(`RFIF_ADDR_MODE, 8'h03);
      for (k = 0; k < 200; k = k + 1) begin
        @(posedge aclk);
        if (serial_tx_data_out !== 1'b0) seen = 1'b1;
      end
      `CHK("tx line", 1'b0, seen)
      `CHK("pins_active", 1'b1, pins_active)
      wr(`RFIF_ADDR_MODE, 8'h00);
      $display("half duplex test done");
    end
  endtask
  task tx_case(input [7:0] cod, input integer b, input integer n, input [15:0] exp);
    integer k;
    reg [15:0] got;
    begin
      got = 16'h0;
      wr(`RFIF_ADDR_TX_STATUS, 8'h00);
      wr(`RFIF_ADDR_BAUD, b);
      wr(`RFIF_ADDR_CODING, cod);
      wr(`RFIF_ADDR_IRQ_MASK, 8'h08);
      wr(`RFIF_ADDR_TX_DATA, 8'ha5);
      wr(`RFIF_ADDR_MODE, 8'h01);
      for (k = 0; k < 400 && serial_tx_data_out !== 1'b1; k = k + 1) @(posedge aclk);
      if (k == 400) hang;
      repeat ((b + 1) * 64 / n) @(posedge aclk);
      for (k = 0; k < n; k = k + 1) begin
        got = {got[14:0], serial_tx_data_out};
        repeat ((b + 1) * 128 / n) @(posedge aclk);
      end
      `CHK("tx chips", exp, got)
      `CHK("irq_tx", 1'b1, irq_tx)
      rd(`RFIF_ADDR_IRQ_STATUS, 8'h08, 8'h08);
      `CHK("irq_tx", 1'b0, irq_tx)
      wr(`RFIF_ADDR_MODE, 8'h00);
      $display("tx case %h done", cod);
    end
  endtask
  task rx_case(input [7:0] cod, input [1:0] code, input [7:0] pat, input [7:0] d);
    begin
      wr(`RFIF_ADDR_RX_STATUS, 8'h00);
      wr(`RFIF_ADDR_BAUD, 8'h00);
      wr(`RFIF_ADDR_START_PATTERN, pat);
      wr(`RFIF_ADDR_CODING, cod);
      wr(`RFIF_ADDR_IRQ_MASK, 8'h05);
      rd(`RFIF_ADDR_IRQ_STATUS, 8'h00, 8'h00);
      wr(`RFIF_ADDR_MODE, 8'h02);
      if (cod[7]) rfif_radio_model_i.match_pulse;
      rfif_radio_model_i.send(cod[7] ? {3{d}} : {8'h00, pat, d}, code);
      repeat (24) @(posedge aclk);
      `CHK("irq_rx", 1'b1, irq_rx)
      rd(`RFIF_ADDR_RX_STATUS, 8'h07, 8'h07);
      rd(`RFIF_ADDR_RX_DATA, 8'hff, d);
      rd(`RFIF_ADDR_IRQ_STATUS, 8'h05, 8'h05);
      `CHK("irq_rx", 1'b0, irq_rx)
      wr(`RFIF_ADDR_MODE, 8'h00);
      $display("rx case %h done", cod);
    end
  endtask
  initial begin
    repeat (100000) @(posedge aclk);
    hang;
  end
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    test_regs;
    test_duplex;
    tx_case(8'h00, 1, 8, 16'h00a5);
    tx_case(8'h01, 0, 8, 16'h00a5);
    tx_case(8'h21, 0, 16, 16'h9966);
    rx_case(8'h40, 2'h0, 8'hd3, 8'h5a);
    rx_case(8'h61, 2'h1, 8'hd3, 8'hc5);
    rx_case(8'h62, 2'h2, 8'h96, 8'h3c);
    rx_case(8'h90, 2'h0, 8'h00, 8'h69);
    tally_and_finish;
  end
endmodule // rf_pcm_bitstream_interface_tb
